// [logic/ssfc_map.svh]
// Purpose: Constants of the servo special-function configuration block
// Assumes: Parameter words addressed by their word address, 32-bit data port
// Notes: Offsets below, then resets, the function list and timing counts
`ifndef SSFC_MAP_SVH
`define SSFC_MAP_SVH
`define SSFC_ADR_GEAR1 16'h0300
`define SSFC_ADR_GEAR2 16'h0278
`define SSFC_ADR_GEAR3 16'h027A
`define SSFC_ADR_GEAR4 16'h027C
`define SSFC_ADR_RSVD_A 16'h027E
`define SSFC_ADR_RSVD_B 16'h0280
`define SSFC_ADR_SF1 16'h0282
`define SSFC_ADR_SF2 16'h0284
`define SSFC_ADR_SETTLE 16'h0286
`define SSFC_ADR_TRACK 16'h0288
`define SSFC_ADR_ZST 16'h0302
`define SSFC_ADR_FST 16'h0304
`define SSFC_RST_GEAR1 32'h00000001
`define SSFC_RST_GEAR2 32'h00000080
`define SSFC_RST_GEAR3 32'h00000010
`define SSFC_RST_GEAR4 32'h00000080
`define SSFC_RST_SETTLE 16'h000F
`define SSFC_RST_ZST 16'h000A
`define SSFC_RST_FST 16'h0000
`define SSFC_SF1_ABN 6
`define SSFC_SF1_WIRE 8
`define SSFC_SF1_CUT 9
`define SSFC_SF1_ZCL 10
`define SSFC_SF1_INH 11
`define SSFC_SF1_PHL 12
`define SSFC_SF1_ENC 13
`define SSFC_SF1_FRIC 15
`define SSFC_SF2_LV 2
`define SSFC_SF2_B4 4
`define SSFC_SF2_SCL 5
`define SSFC_SF2_ROUTE 9
`define SSFC_CLK_MHZ 100
`define SSFC_TICK_US 1000
`define SSFC_TICK_CYCLES (`SSFC_TICK_US * `SSFC_CLK_MHZ)
`define SSFC_SETTLE_TICKS 100
`define SSFC_SLEW_STEP 16'h0010
`endif

// [logic/ssfc_pkg.sv]
// Purpose: Types of the servo special-function configuration block
// Assumes: Constants come from ssfc_map.svh
// Notes: One packed state struct carries all registers
package ssfc_pkg;
  typedef struct packed {
    logic [31:0] gear1;
    logic [31:0] gear2;
    logic [31:0] gear3;
    logic [31:0] gear4;
    logic [15:0] sf1;
    logic [15:0] sf2;
    logic [15:0] settle;
    logic [15:0] track;
    logic [15:0] zst;
    logic [15:0] fst;
    logic [31:0] rdata;
    logic rvalid;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [16:0] tick_cnt;
    logic tick;
    logic [31:0] gear;
    logic clamp;
    logic lock;
    logic [15:0] spd;
    logic [15:0] fric;
    logic [15:0] fric_step;
    logic fric_ramp;
    logic lv_alarm;
    logic [6:0] alarms;
    logic alm;
    logic warn;
    logic [1:0] pulse;
    logic [23:0] in_cnt;
    logic done;
  } ssfc_state_s;
endpackage

// [logic/ssfc_top.sv]
// Purpose: Gear numerator select, protection gating, clamp and pulse inhibit
// Assumes: Pins pass two flip-flops; condition inputs come from mclk logic
// Notes: Speeds are magnitudes; the caller keeps the sign
`timescale 1ns/1ps
`include "ssfc_map.svh"
module ssfc_top
  import ssfc_pkg::*;
#(
  parameter int TICK_CYCLES = `SSFC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Parameter access
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  output logic [31:0] par_rdata,
  output logic par_rvalid,
  // Pins, asynchronous
  input wire logic numerator_select_lo,
  input wire logic numerator_select_hi,
  input wire logic zero_speed_lock,
  input wire logic negative_travel_limit,
  input wire logic positive_travel_limit,
  input wire logic pulse_fwd_in,
  input wire logic pulse_rev_in,
  // Input assignment and modes
  input wire logic select_lo_assigned,
  input wire logic select_hi_assigned,
  input wire logic speed_mode,
  input wire logic pulse_train_position_mode,
  input wire logic analog_source,
  input wire logic full_closed_loop,
  input wire logic semi_auto_tuning,
  input wire logic tuning_adjusting,
  // Commands and measurements
  input wire logic [15:0] speed_cmd_in,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] friction_in,
  // Raw alarm conditions
  input wire logic pulse_abnormal,
  input wire logic wiring_error,
  input wire logic phase_cut,
  input wire logic input_phase_loss,
  input wire logic encoder_output_fault,
  input wire logic b4_condition,
  input wire logic scale_break,
  input wire logic low_voltage,
  input wire logic routed_alarm,
  input wire logic alarm_clear,
  // Results
  output logic [31:0] gear_numerator,
  output logic zero_clamp_active,
  output logic position_lock,
  output logic [15:0] speed_cmd_out,
  output logic pulse_fwd_out,
  output logic pulse_rev_out,
  output logic [15:0] friction_out,
  output logic abnormal_pulse_alarm,
  output logic wiring_alarm,
  output logic phase_cut_alarm,
  output logic phase_loss_alarm,
  output logic encoder_output_alarm,
  output logic ignorable_alarm_b4,
  output logic linear_scale_break_alarm,
  output logic low_voltage_alarm,
  output logic alarm_output,
  output logic warning_output,
  output logic inertia_done
);

  ssfc_state_s st;
  ssfc_state_s next_st;
  logic [6:0] pins;
  logic clamp_cond;

  assign pins = {pulse_rev_in, pulse_fwd_in, positive_travel_limit, negative_travel_limit,
                 zero_speed_lock, numerator_select_hi, numerator_select_lo};

  // Reserved and unmapped words answer zero
  function automatic logic [31:0] read_word(input ssfc_state_s s, input logic [15:0] a);
    case (a)
      `SSFC_ADR_GEAR1: read_word = s.gear1;
      `SSFC_ADR_GEAR2: read_word = s.gear2;
      `SSFC_ADR_GEAR3: read_word = s.gear3;
      `SSFC_ADR_GEAR4: read_word = s.gear4;
      `SSFC_ADR_SF1: read_word = {16'h0000, s.sf1};
      `SSFC_ADR_SF2: read_word = {16'h0000, s.sf2};
      `SSFC_ADR_SETTLE: read_word = {16'h0000, s.settle};
      `SSFC_ADR_TRACK: read_word = {16'h0000, s.track};
      `SSFC_ADR_ZST: read_word = {16'h0000, s.zst};
      `SSFC_ADR_FST: read_word = {16'h0000, s.fst};
      default: read_word = 32'h00000000;
    endcase
  endfunction

  assign clamp_cond = speed_mode && st.s2[2] && (speed_cmd_in < st.zst);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // Two-stage synchronisers for all pins
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    // Millisecond tick, shared by ramps and the settle counter
    next_st.tick = 1'b0;
    if (st.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = 17'h00000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 17'h00001;
    end
    // Parameter port; reserved words fall to default and are dropped
    if (par_wr) begin
      case (par_addr)
        `SSFC_ADR_GEAR1: next_st.gear1 = par_wdata;
        `SSFC_ADR_GEAR2: next_st.gear2 = par_wdata;
        `SSFC_ADR_GEAR3: next_st.gear3 = par_wdata;
        `SSFC_ADR_GEAR4: next_st.gear4 = par_wdata;
        `SSFC_ADR_SF1: next_st.sf1 = par_wdata[15:0];
        `SSFC_ADR_SF2: next_st.sf2 = par_wdata[15:0];
        `SSFC_ADR_SETTLE: next_st.settle = par_wdata[15:0];
        `SSFC_ADR_TRACK: next_st.track = par_wdata[15:0];
        `SSFC_ADR_ZST: next_st.zst = par_wdata[15:0];
        `SSFC_ADR_FST: next_st.fst = par_wdata[15:0];
        default: next_st.rvalid = st.rvalid;
      endcase
    end
    next_st.rvalid = par_rd;
    next_st.rdata = par_rd ? read_word(st, par_addr) : 32'h00000000;
    // Numerator select; an unassigned select input counts as low
    case ({select_hi_assigned && st.s2[1], select_lo_assigned && st.s2[0]})
      2'b01: next_st.gear = st.gear2;
      2'b10: next_st.gear = st.gear3;
      2'b11: next_st.gear = st.gear4;
      default: next_st.gear = st.gear1;
    endcase
    // Protection gating
    next_st.alarms[0] = pulse_abnormal && !st.sf1[`SSFC_SF1_ABN];
    next_st.alarms[1] = wiring_error && st.sf1[`SSFC_SF1_WIRE];
    next_st.alarms[2] = phase_cut && st.sf1[`SSFC_SF1_CUT];
    next_st.alarms[3] = input_phase_loss && !st.sf1[`SSFC_SF1_PHL];
    next_st.alarms[4] = encoder_output_fault && !st.sf1[`SSFC_SF1_ENC];
    next_st.alarms[5] = b4_condition && !st.sf2[`SSFC_SF2_B4];
    next_st.alarms[6] = scale_break && full_closed_loop && st.sf2[`SSFC_SF2_SCL];
    // Low voltage: latched mode holds until cleared, a new event beats the clear
    if (st.sf2[`SSFC_SF2_LV]) begin
      next_st.lv_alarm = low_voltage;
    end else begin
      next_st.lv_alarm = low_voltage || (st.lv_alarm && !alarm_clear);
    end
    next_st.alm = routed_alarm && st.sf2[`SSFC_SF2_ROUTE];
    next_st.warn = routed_alarm && !st.sf2[`SSFC_SF2_ROUTE];
    // Zero clamp
    next_st.clamp = clamp_cond;
    next_st.lock = clamp_cond && !st.sf1[`SSFC_SF1_ZCL];
    if (clamp_cond && !st.sf1[`SSFC_SF1_ZCL]) begin
      next_st.spd = 16'h0000;
    end else if (clamp_cond && !analog_source) begin
      next_st.spd = 16'h0000;
    end else if (st.sf1[`SSFC_SF1_ZCL] && analog_source) begin
      // Slewed on the tick; a coarse stand-in for the S-curve
      if (st.tick) begin
        if (clamp_cond) begin
          next_st.spd = (st.spd > `SSFC_SLEW_STEP) ? st.spd - `SSFC_SLEW_STEP : 16'h0000;
        end else if (st.spd + `SSFC_SLEW_STEP < speed_cmd_in) begin
          next_st.spd = st.spd + `SSFC_SLEW_STEP;
        end else if (st.spd > speed_cmd_in + `SSFC_SLEW_STEP) begin
          next_st.spd = st.spd - `SSFC_SLEW_STEP;
        end else begin
          next_st.spd = speed_cmd_in;
        end
      end
    end else begin
      next_st.spd = speed_cmd_in;
    end
    // Pulse inhibit toward an active travel limit
    next_st.pulse = {st.s2[6], st.s2[5]};
    if (pulse_train_position_mode && st.sf1[`SSFC_SF1_INH]) begin
      next_st.pulse[0] = st.s2[5] && !st.s2[4];
      next_st.pulse[1] = st.s2[6] && !st.s2[3];
    end
    // Friction compensation below the zero-speed threshold
    if (motor_speed >= st.zst) begin
      next_st.fric = friction_in;
      next_st.fric_ramp = 1'b0;
    end else if (st.sf1[`SSFC_SF1_FRIC]) begin
      if (!st.fric_ramp) begin
        next_st.fric_ramp = 1'b1;
        if (st.fst == 16'h0000) begin
          next_st.fric = 16'h0000;
        end else begin
          next_st.fric_step = (st.fric / st.fst) | 16'h0001;
        end
      end else if (st.tick) begin
        next_st.fric = (st.fric > st.fric_step) ? st.fric - st.fric_step : 16'h0000;
      end
    end else begin
      next_st.fric_ramp = 1'b0;
    end
    // Inertia settle: settle word counts tenths, each worth SETTLE_TICKS ticks
    if (!semi_auto_tuning) begin
      next_st.in_cnt = 24'h000000;
      next_st.done = 1'b0;
    end else if (!tuning_adjusting) begin
      next_st.in_cnt = 24'h000000;
    end else if (!st.done) begin
      if (st.in_cnt >= 24'(st.settle * `SSFC_SETTLE_TICKS)) begin
        next_st.done = 1'b1;
      end else if (st.tick) begin
        next_st.in_cnt = st.in_cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
      st.gear1 <= `SSFC_RST_GEAR1;
      st.gear2 <= `SSFC_RST_GEAR2;
      st.gear3 <= `SSFC_RST_GEAR3;
      st.gear4 <= `SSFC_RST_GEAR4;
      st.gear <= `SSFC_RST_GEAR1;
      st.settle <= `SSFC_RST_SETTLE;
      st.zst <= `SSFC_RST_ZST;
      st.fst <= `SSFC_RST_FST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign par_rdata = st.rdata;
  assign par_rvalid = st.rvalid;
  assign gear_numerator = st.gear;
  assign zero_clamp_active = st.clamp;
  assign position_lock = st.lock;
  assign speed_cmd_out = st.spd;
  assign pulse_fwd_out = st.pulse[0];
  assign pulse_rev_out = st.pulse[1];
  assign friction_out = st.fric;
  assign abnormal_pulse_alarm = st.alarms[0];
  assign wiring_alarm = st.alarms[1];
  assign phase_cut_alarm = st.alarms[2];
  assign phase_loss_alarm = st.alarms[3];
  assign encoder_output_alarm = st.alarms[4];
  assign ignorable_alarm_b4 = st.alarms[5];
  assign linear_scale_break_alarm = st.alarms[6];
  assign low_voltage_alarm = st.lv_alarm;
  assign alarm_output = st.alm;
  assign warning_output = st.warn;
  assign inertia_done = st.done;

  ////////////////////////////////////////////////////////////////////////////
  property p_gear_default;
    @(posedge mclk) disable iff (srst)
    !select_lo_assigned && !select_hi_assigned |=> gear_numerator == $past(st.gear1);
  endproperty
  a_gear_default: assert property (p_gear_default) else $error("gear not first numerator");

  property p_gear_four;
    @(posedge mclk) disable iff (srst)
    select_lo_assigned && select_hi_assigned && st.s2[1:0] == 2'b11
      |=> gear_numerator == $past(st.gear4);
  endproperty
  a_gear_four: assert property (p_gear_four) else $error("gear not fourth numerator");

  property p_abn_gate;
    @(posedge mclk) disable iff (srst)
    pulse_abnormal |=> abnormal_pulse_alarm == !$past(st.sf1[`SSFC_SF1_ABN]);
  endproperty
  a_abn_gate: assert property (p_abn_gate) else $error("abnormal pulse gating wrong");

  property p_scale_gate;
    @(posedge mclk) disable iff (srst)
    linear_scale_break_alarm |-> $past(full_closed_loop && st.sf2[`SSFC_SF2_SCL]);
  endproperty
  a_scale_gate: assert property (p_scale_gate) else $error("scale alarm not enabled");

  property p_route;
    @(posedge mclk) disable iff (srst)
    routed_alarm |=> (alarm_output != warning_output) &&
      (alarm_output == $past(st.sf2[`SSFC_SF2_ROUTE]));
  endproperty
  a_route: assert property (p_route) else $error("routed alarm on wrong output");

  sequence s_lv_latched;
    low_voltage_alarm && !st.sf2[`SSFC_SF2_LV] && !alarm_clear;
  endsequence
  property p_lv_latch;
    @(posedge mclk) disable iff (srst)
    s_lv_latched |=> low_voltage_alarm;
  endproperty
  a_lv_latch: assert property (p_lv_latch) else $error("low voltage latch lost");

  property p_both_limits;
    @(posedge mclk) disable iff (srst)
    pulse_train_position_mode && st.sf1[`SSFC_SF1_INH] && st.s2[3] && st.s2[4]
      |=> !pulse_fwd_out && !pulse_rev_out;
  endproperty
  a_both_limits: assert property (p_both_limits) else $error("pulse passed both limits");

  property p_clamp_cond;
    @(posedge mclk) disable iff (srst)
    zero_clamp_active |-> $past(speed_mode && st.s2[2] && speed_cmd_in < st.zst);
  endproperty
  a_clamp_cond: assert property (p_clamp_cond) else $error("clamp without conditions");

  property p_internal_zero;
    @(posedge mclk) disable iff (srst)
    clamp_cond && !analog_source |=> speed_cmd_out == 16'h0000;
  endproperty
  a_internal_zero: assert property (p_internal_zero) else $error("clamped command not zero");

  property p_done_cause;
    @(posedge mclk) disable iff (srst)
    $rose(inertia_done) |-> $past(semi_auto_tuning && tuning_adjusting, 1);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("inertia done without tuning");

  property p_wire_gate;
    @(posedge mclk) disable iff (srst)
    wiring_error |=> wiring_alarm == $past(st.sf1[`SSFC_SF1_WIRE]);
  endproperty
  a_wire_gate: assert property (p_wire_gate) else $error("wiring alarm gating wrong");

  property p_cut_gate;
    @(posedge mclk) disable iff (srst)
    phase_cut |=> phase_cut_alarm == $past(st.sf1[`SSFC_SF1_CUT]);
  endproperty
  a_cut_gate: assert property (p_cut_gate) else $error("cut-off alarm gating wrong");

  property p_phl_gate;
    @(posedge mclk) disable iff (srst)
    input_phase_loss |=> phase_loss_alarm == !$past(st.sf1[`SSFC_SF1_PHL]);
  endproperty
  a_phl_gate: assert property (p_phl_gate) else $error("phase loss gating wrong");

  property p_enc_gate;
    @(posedge mclk) disable iff (srst)
    encoder_output_fault |=> encoder_output_alarm == !$past(st.sf1[`SSFC_SF1_ENC]);
  endproperty
  a_enc_gate: assert property (p_enc_gate) else $error("encoder alarm gating wrong");

  property p_b4_gate;
    @(posedge mclk) disable iff (srst)
    b4_condition |=> ignorable_alarm_b4 == !$past(st.sf2[`SSFC_SF2_B4]);
  endproperty
  a_b4_gate: assert property (p_b4_gate) else $error("ignorable alarm gating wrong");

  property p_pulse_free;
    @(posedge mclk) disable iff (srst)
    !st.sf1[`SSFC_SF1_INH] |=> pulse_fwd_out == $past(st.s2[5]) &&
      pulse_rev_out == $past(st.s2[6]);
  endproperty
  a_pulse_free: assert property (p_pulse_free) else $error("pulse blocked");

  property p_lock_zero;
    @(posedge mclk) disable iff (srst)
    clamp_cond && !st.sf1[`SSFC_SF1_ZCL] |=> position_lock && speed_cmd_out == 16'h0000;
  endproperty
  a_lock_zero: assert property (p_lock_zero) else $error("clamp did not lock");

  property p_rsvd_read;
    @(posedge mclk) disable iff (srst)
    par_rd && (par_addr == `SSFC_ADR_RSVD_A || par_addr == `SSFC_ADR_RSVD_B)
      |=> par_rvalid && par_rdata == 32'h00000000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word not zero");

  property p_done_hold;
    @(posedge mclk) disable iff (srst)
    inertia_done && semi_auto_tuning |=> inertia_done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("inertia done dropped");

  property p_fric_hold;
    @(posedge mclk) disable iff (srst)
    motor_speed < st.zst && !st.sf1[`SSFC_SF1_FRIC] |=> friction_out == $past(friction_out);
  endproperty
  a_fric_hold: assert property (p_fric_hold) else $error("friction value not held");

endmodule

// [dv/ssfc_host.sv]
// Purpose: Motion controller model that feeds pulse and speed commands to the drive
// Assumes: Bench sets requests just after a rising edge of mclk
// Notes: Lines fall idle low whenever no pulse is requested
`timescale 1ns/1ps
module ssfc_host (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic fwd_req,
  input wire logic rev_req,
  input wire logic [15:0] cmd,
  // Lines into the drive
  output logic pulse_fwd_in,
  output logic pulse_rev_in,
  output logic [15:0] speed_cmd_in
);
  initial begin
    pulse_fwd_in = 1'b0;
    pulse_rev_in = 1'b0;
    speed_cmd_in = 16'h0000;
  end
  // Requests are taken on the edge and launched just after it, so the bench never races us
  always @(posedge mclk) begin
    pulse_fwd_in <= #1 fwd_req;
    pulse_rev_in <= #1 rev_req;
    speed_cmd_in <= #1 cmd;
  end
endmodule

// [dv/tb_servo_special_function_config.sv]
// Purpose: Self-checking bench of the special-function configuration block
// Assumes: Inputs change 1 ns after the rising edge; tick shortened to 4 cycles
// Notes: Pins need 3 cycles to reach outputs, same-clock inputs 1 cycle
`timescale 1ns/1ps
`include "ssfc_map.svh"
module tb_servo_special_function_config;
  import ssfc_pkg::*;
  logic mclk, srst, par_wr, par_rd, par_rvalid;
  logic [15:0] par_addr, cmd, speed_cmd_in, motor_speed, friction_in, speed_cmd_out, friction_out;
  logic [31:0] par_wdata, par_rdata, gear_numerator;
  logic numerator_select_lo, numerator_select_hi, zero_speed_lock, negative_travel_limit;
  logic positive_travel_limit, pulse_fwd_in, pulse_rev_in, fwd_req, rev_req;
  logic select_lo_assigned, select_hi_assigned, speed_mode, pulse_train_position_mode;
  logic analog_source, full_closed_loop, semi_auto_tuning, tuning_adjusting;
  logic pulse_abnormal, wiring_error, phase_cut, input_phase_loss, encoder_output_fault;
  logic b4_condition, scale_break, low_voltage, routed_alarm, alarm_clear;
  logic zero_clamp_active, position_lock, pulse_fwd_out, pulse_rev_out, abnormal_pulse_alarm;
  logic wiring_alarm, phase_cut_alarm, phase_loss_alarm, encoder_output_alarm;
  logic ignorable_alarm_b4, linear_scale_break_alarm, low_voltage_alarm;
  logic alarm_output, warning_output, inertia_done;
  int mismatches = 0;
  int n_tests = 0;

  ssfc_top #(.TICK_CYCLES(4)) uut (.*);
  ssfc_host host (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe is held across the sampling edge, then a quiet cycle follows
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    par_addr = a;
    par_wdata = d;
    par_wr = 1'b1;
    step(1);
    par_wr = 1'b0;
    step(1);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    d = 'x;
    par_addr = a;
    par_rd = 1'b1;
    step(1);
    par_rd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (par_rvalid === 1'b1) begin
        d = par_rdata;
        break;
      end
      step(1);
    end
    check(d, exp);
    step(1);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(gear_numerator, 32'h00000001);
    rd_chk(`SSFC_ADR_GEAR1, 32'h00000001);
    rd_chk(`SSFC_ADR_GEAR2, 32'h00000080);
    rd_chk(`SSFC_ADR_GEAR3, 32'h00000010);
    rd_chk(`SSFC_ADR_GEAR4, 32'h00000080);
    rd_chk(`SSFC_ADR_SF1, 32'h00000000);
    rd_chk(`SSFC_ADR_SF2, 32'h00000000);
    rd_chk(`SSFC_ADR_SETTLE, 32'h0000000F);
    rd_chk(`SSFC_ADR_TRACK, 32'h00000000);
    rd_chk(`SSFC_ADR_ZST, 32'h0000000A);
    rd_chk(`SSFC_ADR_FST, 32'h00000000);
  endtask

  task automatic t_rsvd;
    wr(`SSFC_ADR_RSVD_A, 32'h12345678);
    wr(`SSFC_ADR_RSVD_B, 32'h0000FFFF);
    wr(16'h0283, 32'h0000FFFF);
    rd_chk(`SSFC_ADR_RSVD_A, 32'h00000000);
    rd_chk(`SSFC_ADR_RSVD_B, 32'h00000000);
    rd_chk(16'h0283, 32'h00000000);
    rd_chk(`SSFC_ADR_SF1, 32'h00000000);
  endtask

  task automatic t_gear;
    logic [31:0] g [4];
    g = '{32'h00000011, 32'h00000022, 32'h00000033, 32'h1FFFFFFF};
    motor_speed = 16'h0000;
    wr(`SSFC_ADR_GEAR1, g[0]);
    wr(`SSFC_ADR_GEAR2, g[1]);
    wr(`SSFC_ADR_GEAR3, g[2]);
    wr(`SSFC_ADR_GEAR4, g[3]);
    select_lo_assigned = 1'b1;
    select_hi_assigned = 1'b1;
    for (int s = 0; s < 4; s++) begin
      numerator_select_lo = s[0];
      numerator_select_hi = s[1];
      step(4);
      check(gear_numerator, g[s]);
    end
    // Unassigned select reads as zero even with its pin high
    select_hi_assigned = 1'b0;
    step(2);
    check(gear_numerator, g[1]);
    select_lo_assigned = 1'b0;
    step(2);
    check(gear_numerator, g[0]);
  endtask

  task automatic t_prot;
    logic k;
    {pulse_abnormal, wiring_error, phase_cut, input_phase_loss} = 4'hF;
    {encoder_output_fault, b4_condition, scale_break, routed_alarm} = 4'hF;
    full_closed_loop = 1'b1;
    for (int i = 0; i < 2; i++) begin
      k = i[0];
      wr(`SSFC_ADR_SF1, k ? 32'h00003340 : 32'h00000000);
      wr(`SSFC_ADR_SF2, k ? 32'h00000230 : 32'h00000000);
      check(abnormal_pulse_alarm, !k);
      check(wiring_alarm, k);
      check(phase_cut_alarm, k);
      check(phase_loss_alarm, !k);
      check(encoder_output_alarm, !k);
      check(ignorable_alarm_b4, !k);
      check(linear_scale_break_alarm, k);
      check({alarm_output, warning_output}, {k, !k});
    end
    full_closed_loop = 1'b0;
    step(2);
    check(linear_scale_break_alarm, 32'h0);
    {pulse_abnormal, wiring_error, phase_cut, input_phase_loss} = 4'h0;
    {encoder_output_fault, b4_condition, scale_break, routed_alarm} = 4'h0;
    step(2);
    check({alarm_output, warning_output}, 32'h0);
  endtask

  task automatic t_lv;
    wr(`SSFC_ADR_SF2, 32'h00000000);
    low_voltage = 1'b1;
    step(2);
    low_voltage = 1'b0;
    step(3);
    check(low_voltage_alarm, 32'h1);
    // A new event in the clearing cycle wins
    {low_voltage, alarm_clear} = 2'b11;
    step(1);
    {low_voltage, alarm_clear} = 2'b00;
    step(1);
    check(low_voltage_alarm, 32'h1);
    alarm_clear = 1'b1;
    step(1);
    alarm_clear = 1'b0;
    step(1);
    check(low_voltage_alarm, 32'h0);
    wr(`SSFC_ADR_SF2, 32'h00000004);
    low_voltage = 1'b1;
    step(2);
    check(low_voltage_alarm, 32'h1);
    low_voltage = 1'b0;
    step(3);
    check(low_voltage_alarm, 32'h0);
  endtask

  task automatic t_pulse;
    logic [3:0] pos_t, neg_t;
    logic b;
    pos_t = 4'b1011;
    neg_t = 4'b1101;
    pulse_train_position_mode = 1'b1;
    fwd_req = 1'b1;
    rev_req = 1'b1;
    for (int c = 0; c < 4; c++) begin
      b = (c != 0);
      wr(`SSFC_ADR_SF1, b ? 32'h00000800 : 32'h00000000);
      positive_travel_limit = pos_t[c];
      negative_travel_limit = neg_t[c];
      step(5);
      check(pulse_fwd_out, !(b && pos_t[c]));
      check(pulse_rev_out, !(b && neg_t[c]));
    end
    {fwd_req, rev_req, positive_travel_limit, negative_travel_limit} = 4'h0;
    pulse_train_position_mode = 1'b0;
  endtask

  task automatic t_clamp;
    wr(`SSFC_ADR_SF1, 32'h00000000);
    speed_mode = 1'b1;
    zero_speed_lock = 1'b1;
    analog_source = 1'b0;
    cmd = 16'h0005;
    step(6);
    check({zero_clamp_active, position_lock}, 32'h3);
    check(speed_cmd_out, 32'h0);
    analog_source = 1'b1;
    step(3);
    check(position_lock, 32'h1);
    analog_source = 1'b0;
    cmd = 16'h000A;
    step(4);
    check(zero_clamp_active, 32'h0);
    check(speed_cmd_out, 32'h0000000A);
    cmd = 16'h0005;
    speed_mode = 1'b0;
    step(4);
    check(zero_clamp_active, 32'h0);
    speed_mode = 1'b1;
    wr(`SSFC_ADR_SF1, 32'h00000400);
    step(4);
    check(zero_clamp_active, 32'h1);
    check(speed_cmd_out, 32'h0);
    // Analog source: slews 0x10 per tick up to the command, then down to zero when clamped
    analog_source = 1'b1;
    cmd = 16'h0040;
    step(30);
    check(speed_cmd_out, 32'h00000040);
    cmd = 16'h0005;
    step(3);
    check(speed_cmd_out != 16'h0000, 32'h1);
    step(30);
    check(speed_cmd_out, 32'h0);
    zero_speed_lock = 1'b0;
    speed_mode = 1'b0;
    analog_source = 1'b0;
  endtask

  task automatic t_fric;
    wr(`SSFC_ADR_FST, 32'h00000004);
    motor_speed = 16'h0020;
    friction_in = 16'h0040;
    step(2);
    check(friction_out, 32'h00000040);
    {motor_speed, friction_in} = {16'h0002, 16'h0000};
    step(30);
    check(friction_out, 32'h00000040);
    wr(`SSFC_ADR_SF1, 32'h00008000);
    step(3);
    check(friction_out != 16'h0000, 32'h1);
    step(30);
    check(friction_out, 32'h0);
  endtask

  task automatic t_inertia;
    wr(`SSFC_ADR_SETTLE, 32'h00000001);
    semi_auto_tuning = 1'b1;
    tuning_adjusting = 1'b1;
    step(380);
    check(inertia_done, 32'h0);
    step(40);
    check(inertia_done, 32'h1);
    semi_auto_tuning = 1'b0;
    tuning_adjusting = 1'b0;
    step(2);
    check(inertia_done, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Whole run is about 710 cycles; the limit leaves a wide margin
  initial begin
    #100us;
    mismatches++;
    stop_test();
  end

  initial begin
    {srst, par_wr, par_rd, par_addr, par_wdata, cmd, fwd_req, rev_req} = '0;
    {motor_speed, friction_in, numerator_select_lo, numerator_select_hi} = '0;
    {zero_speed_lock, negative_travel_limit, positive_travel_limit} = '0;
    {select_lo_assigned, select_hi_assigned, speed_mode, pulse_train_position_mode} = '0;
    {analog_source, full_closed_loop, semi_auto_tuning, tuning_adjusting} = '0;
    {pulse_abnormal, wiring_error, phase_cut, input_phase_loss, encoder_output_fault} = '0;
    {b4_condition, scale_break, low_voltage, routed_alarm, alarm_clear} = '0;
    srst = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_reset();
    t_rsvd();
    t_gear();
    t_prot();
    t_lv();
    t_pulse();
    t_clamp();
    t_fric();
    t_inertia();
    stop_test();
  end
endmodule
